// ==== logic/iwt_consts.svh ====
`ifndef IWT_CONSTS_SVH
`define IWT_CONSTS_SVH

// ============================================================
// target address and byte framing
`define IWT_TARGET_ADDR  7'h75
`define IWT_BITS_PER_BYTE 4'h8
`define IWT_DIR_WRITE    1'h0

// ============================================================
// reset values
`define IWT_PIN_IDLE     2'h3
`define IWT_SHIFT_RESET  8'h00
`define IWT_COUNT_RESET  4'h0

`endif

// ==== logic/iwt_pkg.sv ====
`default_nettype none

// ============================================================
// shared types of the write-only two-wire target
package iwt_pkg;

  // receive state machine
  typedef enum logic [2:0] {
    IWT_IDLE      = 3'h0,
    IWT_ADDR      = 3'h1,
    IWT_ADDR_ACK  = 3'h2,
    IWT_DATA      = 3'h3,
    IWT_DATA_ACK  = 3'h4,
    IWT_DATA_NACK = 3'h5,
    IWT_IGNORE    = 3'h6
  } iwt_state_e;

  // the two bus lines sampled together
  typedef struct packed {
    logic scl;
    logic sda;
  } iwt_pins_s;

  // one received byte on the user stream
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } iwt_word_s;

endpackage

`default_nettype wire

// ==== logic/iwt_sync.sv ====
`timescale 1ns/1ps
`include "iwt_consts.svh"
`default_nettype none

// ============================================================
// three-stage synchroniser with agreement filter for both lines
module iwt_sync (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // raw pins and filtered result
  input  wire iwt_pkg::iwt_pins_s pins_in,
  output var  iwt_pkg::iwt_pins_s pins_out
);

  iwt_pkg::iwt_pins_s stage1;
  iwt_pkg::iwt_pins_s stage2;
  iwt_pkg::iwt_pins_s stage3;

  // shift chain; lines rest high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= `IWT_PIN_IDLE;
      stage2 <= `IWT_PIN_IDLE;
      stage3 <= `IWT_PIN_IDLE;
    end else if (ce) begin
      stage1 <= pins_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a line changes only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_out <= `IWT_PIN_IDLE;
    end else if (ce) begin
      if (stage2.scl == stage3.scl) begin
        pins_out.scl <= stage3.scl;
      end
      if (stage2.sda == stage3.sda) begin
        pins_out.sda <= stage3.sda;
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/iwt_buf.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// two-entry buffer, output word held in a register
module iwt_buf (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // filling side
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire iwt_pkg::iwt_word_s in_word,
  // draining side
  output logic                   out_valid,
  input  wire logic              out_ready,
  output iwt_pkg::iwt_word_s     out_word
);

  iwt_pkg::iwt_word_s tail_word;
  logic               tail_valid;
  logic               push;
  logic               pop;

  // room exists while the second entry is free
  assign in_ready = !tail_valid;
  assign push     = in_valid && !tail_valid;
  assign pop      = out_valid && out_ready;

  // head entry is the output register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'h0;
      out_word  <= '0;
    end else if (ce) begin
      if (!out_valid || pop) begin
        if (tail_valid) begin
          out_word  <= tail_word;
          out_valid <= 1'h1;
        end else begin
          out_word  <= in_word;
          out_valid <= push;
        end
      end
    end
  end

  // tail entry fills only while the head is held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tail_valid <= 1'h0;
      tail_word  <= '0;
    end else if (ce) begin
      if (!out_valid || pop) begin
        tail_valid <= 1'h0;
      end else if (push) begin
        tail_word  <= in_word;
        tail_valid <= 1'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/iwt_target.sv ====
// How it works
// - bus idle: both lines released and resting high
// - data changes only while the clock line is low
// - data falling while clock high is a start; begin receiving
// - data rising while clock high is a stop; end the access
// - bytes of exactly eight bits precede each acknowledge slot
// - accept any number of bytes until a stop arrives; a byte that finds both buffer entries full is not acknowledged
// - acknowledge every accepted byte by pulling data low
// - pull data low right after the eighth clock falls
// - release data at the falling edge of the ninth clock
// - first byte holds seven address bits and a direction bit
// - address arrives MSB first; eighth bit low means write
// - writes only; a read never makes the device send data
// - respond only to target address 1110101
// - reset input low holds the device in reset
`timescale 1ns/1ps
`include "iwt_consts.svh"
`default_nettype none

module iwt_target (
  // clock, reset and enable
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  // serial bus lines
  input  wire logic              SCL_IN,
  input  wire logic              SERIAL_DATA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE,
  // received byte stream
  output logic                   RX_VALID,
  input  wire logic              RX_READY,
  output iwt_pkg::iwt_word_s     RX_WORD,
  // status
  output logic                   BUSY,
  output logic                   SELECTED
);

  // ============================================================
  // declarations

  iwt_pkg::iwt_pins_s raw_pins;
  iwt_pkg::iwt_pins_s pins;
  iwt_pkg::iwt_pins_s pins_d;
  iwt_pkg::iwt_state_e state;
  iwt_pkg::iwt_state_e next_state;
  iwt_pkg::iwt_word_s  push_word;

  logic [7:0] shift;
  logic [3:0] bit_count;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       byte_done;
  logic       first_pending;
  logic       push_valid;
  logic       buf_ready;

  // ============================================================
  // helper functions

  // address byte names this target and asks for a write
  function automatic logic addr_ok(input logic [7:0] b);
    addr_ok = (b[7:1] == `IWT_TARGET_ADDR)
           && (b[0] == `IWT_DIR_WRITE);
  endfunction

  // state in which the device drives the acknowledge
  function automatic logic is_ack(input iwt_pkg::iwt_state_e s);
    is_ack = (s == iwt_pkg::IWT_ADDR_ACK)
          || (s == iwt_pkg::IWT_DATA_ACK);
  endfunction

  // state in which bits are being shifted in
  function automatic logic is_shift(input iwt_pkg::iwt_state_e s);
    is_shift = (s == iwt_pkg::IWT_ADDR)
            || (s == iwt_pkg::IWT_DATA);
  endfunction

  // ============================================================
  // input sampling

  // both pins come from outside the clock domain
  assign raw_pins.scl = SCL_IN;
  assign raw_pins.sda = SERIAL_DATA_IN;

  iwt_sync u_sync (
    .clk      (CLK),
    .rst_n    (RST_N),
    .ce       (CE),
    .pins_in  (raw_pins),
    .pins_out (pins)
  );

  // previous filtered levels for edge finding
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pins_d <= `IWT_PIN_IDLE;
    end else if (CE) begin
      pins_d <= pins;
    end
  end

  // ============================================================
  // bus event decode

  // clock edges of the serial line
  assign scl_rise = pins.scl && !pins_d.scl;
  assign scl_fall = !pins.scl && pins_d.scl;

  // data moving while clock stays high marks start or stop
  assign start_seen = pins.scl && pins_d.scl
                   && pins_d.sda && !pins.sda;
  assign stop_seen  = pins.scl && pins_d.scl
                   && !pins_d.sda && pins.sda;

  // falling edge that closes the eighth bit
  assign byte_done = scl_fall
                  && (bit_count == `IWT_BITS_PER_BYTE);

  // ============================================================
  // receive state machine

  // state register; reset pin forces idle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= iwt_pkg::IWT_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // next state from bus events
  always_comb begin
    next_state = state;
    if (start_seen) begin
      next_state = iwt_pkg::IWT_ADDR;
    end else if (stop_seen) begin
      next_state = iwt_pkg::IWT_IDLE;
    end else begin
      unique case (state)
        iwt_pkg::IWT_IDLE: begin
          next_state = iwt_pkg::IWT_IDLE;
        end
        iwt_pkg::IWT_ADDR: begin
          if (byte_done) begin
            if (addr_ok(shift)) begin
              next_state = iwt_pkg::IWT_ADDR_ACK;
            end else begin
              next_state = iwt_pkg::IWT_IGNORE;
            end
          end
        end
        iwt_pkg::IWT_ADDR_ACK: begin
          if (scl_fall) begin
            next_state = iwt_pkg::IWT_DATA;
          end
        end
        iwt_pkg::IWT_DATA: begin
          if (byte_done) begin
            if (buf_ready) begin
              next_state = iwt_pkg::IWT_DATA_ACK;
            end else begin
              next_state = iwt_pkg::IWT_DATA_NACK;
            end
          end
        end
        iwt_pkg::IWT_DATA_ACK: begin
          if (scl_fall) begin
            next_state = iwt_pkg::IWT_DATA;
          end
        end
        iwt_pkg::IWT_DATA_NACK: begin
          if (scl_fall) begin
            next_state = iwt_pkg::IWT_DATA;
          end
        end
        iwt_pkg::IWT_IGNORE: begin
          next_state = iwt_pkg::IWT_IGNORE;
        end
        default: begin
          next_state = iwt_pkg::IWT_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // bit shifting and counting

  // data sampled on each rising clock edge, MSB first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift <= `IWT_SHIFT_RESET;
    end else if (CE) begin
      if (start_seen) begin
        shift <= `IWT_SHIFT_RESET;
      end else if (scl_rise && is_shift(state)
                   && bit_count < `IWT_BITS_PER_BYTE) begin
        shift <= {shift[6:0], pins.sda};
      end
    end
  end

  // counts bits of the current byte, cleared after the slot
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_count <= `IWT_COUNT_RESET;
    end else if (CE) begin
      if (start_seen || stop_seen) begin
        bit_count <= `IWT_COUNT_RESET;
      end else if (scl_rise && is_shift(state)
                   && bit_count < `IWT_BITS_PER_BYTE) begin
        bit_count <= bit_count + 4'h1;
      end else if (scl_fall && (is_ack(state)
                   || state == iwt_pkg::IWT_DATA_NACK)) begin
        bit_count <= `IWT_COUNT_RESET;
      end
    end
  end

  // ============================================================
  // acknowledge driver

  // open drain: only ever pulls low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SDA_OUT <= 1'h0;
    end else if (CE) begin
      SDA_OUT <= 1'h0;
    end
  end

  // drive from eighth fall to ninth fall; changes follow scl low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SDA_OE <= 1'h0;
    end else if (CE) begin
      SDA_OE <= is_ack(next_state);
    end
  end

  // ============================================================
  // stream toward the user

  // marks the first data byte of each access
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_pending <= 1'h0;
    end else if (CE) begin
      if (start_seen) begin
        first_pending <= 1'h1;
      end else if (push_valid) begin
        first_pending <= 1'h0;
      end
    end
  end

  // one-cycle push of an acknowledged data byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      push_valid <= 1'h0;
      push_word  <= '0;
    end else if (CE) begin
      push_valid <= (state == iwt_pkg::IWT_DATA) && byte_done
                 && buf_ready && !start_seen && !stop_seen;
      push_word.first <= first_pending;
      push_word.data  <= shift;
    end
  end

  // room can only grow between decision and push
  iwt_buf u_buf (
    .clk       (CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .in_valid  (push_valid),
    .in_ready  (buf_ready),
    .in_word   (push_word),
    .out_valid (RX_VALID),
    .out_ready (RX_READY),
    .out_word  (RX_WORD)
  );

  // ============================================================
  // status outputs

  // access in progress between start and stop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUSY <= 1'h0;
    end else if (CE) begin
      BUSY <= (next_state != iwt_pkg::IWT_IDLE);
    end
  end

  // address accepted for the current access
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SELECTED <= 1'h0;
    end else if (CE) begin
      SELECTED <= (next_state != iwt_pkg::IWT_IDLE)
               && (next_state != iwt_pkg::IWT_ADDR)
               && (next_state != iwt_pkg::IWT_IGNORE);
    end
  end

endmodule

`default_nettype wire

// ==== testbench/iwt_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bus host that issues write transfers on the two lines
module iwt_host (
  // system clock and wire level of the data line
  input  wire logic clk,
  input  wire logic sda,
  // host drive: clock level and data pull-down
  output logic      scl,
  output logic      sda_low
);
  // both lines released while no transfer runs
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // wait n falling edges, so every change lands off the sampling edge
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_low = 1'b0;
    w(4);
    scl = 1'b1;
    w(4);
    sda_low = 1'b1;
    w(4);
    scl = 1'b0;
    w(4);
  endtask

  // n bits msb first, data moved only with clock low, then ack slot only when n is 8
  task automatic send(input logic [7:0] v, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      sda_low = !v[i];
      w(4);
      scl = 1'b1;
      w(8);
      scl = 1'b0;
      w(4);
    end
    if (n < 8)
      return;
    sda_low = 1'b0;
    w(4);
    scl = 1'b1;
    w(4);
    ack = !sda;
    w(4);
    scl = 1'b0;
    w(4);
  endtask

  // stop: data rises while clock is high, then the bus rests
  task automatic stop();
    sda_low = 1'b1;
    w(4);
    scl = 1'b1;
    w(4);
    sda_low = 1'b0;
    w(8);
  endtask
endmodule

`default_nettype wire

// ==== testbench/iwt_target_props.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// port checker of the two-wire target
module iwt_target_props (
  // clock, reset and enable
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic               CE,
  // serial bus lines
  input wire logic               SCL_IN,
  input wire logic               SERIAL_DATA_IN,
  input wire logic               SDA_OUT,
  input wire logic               SDA_OE,
  // received byte stream
  input wire logic               RX_VALID,
  input wire logic               RX_READY,
  input wire iwt_pkg::iwt_word_s RX_WORD,
  // status
  input wire logic               BUSY,
  input wire logic               SELECTED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // acknowledge: held over the ninth clock, then released
  sequence s_ack_hold;
    SDA_OE [*8];
  endsequence
  sequence s_ack_end;
    !SDA_OE;
  endsequence

  // properties tying outputs to bus and stream events
  property p_ack_len;
    $rose(SDA_OE) |-> s_ack_hold ##[1:24] s_ack_end;
  endproperty
  property p_oe_rise;
    $rose(SDA_OE) |-> !SCL_IN && !SDA_OUT;
  endproperty
  property p_oe_fall;
    $fell(SDA_OE) |-> !SCL_IN;
  endproperty
  property p_idle_free;
    !BUSY |-> !SDA_OE;
  endproperty
  property p_idle_quiet;
    $fell(BUSY) |-> !SELECTED && !$past(SDA_OE);
  endproperty
  property p_sel_ack;
    $rose(SELECTED) |-> $rose(SDA_OE);
  endproperty
  property p_valid_cause;
    $rose(RX_VALID) |-> $past(SDA_OE);
  endproperty
  property p_valid_hold;
    RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_WORD);
  endproperty
  property p_ce_freeze;
    !CE |=> $stable(BUSY) && $stable(SELECTED) && $stable(SDA_OE)
            && $stable(RX_VALID);
  endproperty

  a_ack_len: assert property (p_ack_len)
    else $error("ack pulse length wrong");
  a_oe_rise: assert property (p_oe_rise)
    else $error("ack started with clock high");
  a_oe_fall: assert property (p_oe_fall)
    else $error("ack ended with clock high");
  a_idle_free: assert property (p_idle_free)
    else $error("data pulled while idle");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("selection kept after stop");
  a_sel_ack: assert property (p_sel_ack)
    else $error("selected without ack");
  a_valid_cause: assert property (p_valid_cause)
    else $error("word without ack");
  a_valid_hold: assert property (p_valid_hold)
    else $error("stalled word changed");
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("outputs moved while enable low");
endmodule

bind iwt_target iwt_target_props u_props (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .SCL_IN(SCL_IN),
  .SERIAL_DATA_IN(SERIAL_DATA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_WORD(RX_WORD),
  .BUSY(BUSY), .SELECTED(SELECTED));

`default_nettype wire

// ==== testbench/iwt_target_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// self-checking bench of the two-wire target
module iwt_target_bench;
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic       ka;
    logic       kd;
  } iwt_row_s;

  logic               clk      = 1'b0;
  logic               rst_n    = 1'b0;
  logic               rx_ready = 1'b0;
  logic               ce       = 1'b1;
  logic               scl;
  logic               sda_low;
  logic               sda_oe;
  logic               sda_out;
  logic               rx_valid;
  logic               busy;
  logic               selected;
  logic               ack;
  iwt_pkg::iwt_word_s rx_word;
  int                 errors   = 0;
  int                 n_checks = 0;
  // addr byte, data byte, expected acks: match, boundaries, read,
  // wrong address, address with reversed bit order
  iwt_row_s rows [6] = '{
    '{8'hEA, 8'h3C, 1'b1, 1'b1}, '{8'hEA, 8'h00, 1'b1, 1'b1},
    '{8'hEA, 8'hFF, 1'b1, 1'b1}, '{8'hEB, 8'hA5, 1'b0, 1'b0},
    '{8'hE8, 8'h3C, 1'b0, 1'b0}, '{8'hAE, 8'h3C, 1'b0, 1'b0}};

  // open-drain data line with pull-up
  wire logic sda = !(sda_low || (sda_oe && !sda_out));

  always #5 clk = !clk;

  iwt_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  iwt_target dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .SCL_IN(scl),
    .SERIAL_DATA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_WORD(rx_word),
    .BUSY(busy), .SELECTED(selected));

  // ============================================================
  // compares and closing report
  task automatic chk1(input string name, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic chkw(input string name, input iwt_pkg::iwt_word_s seen,
                      input iwt_pkg::iwt_word_s exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // wait for a word under a bound, compare it, take it
  task automatic pop(input iwt_pkg::iwt_word_s exp);
    int k = 0;
    while (rx_valid !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (rx_valid !== 1'b1) begin
      errors++;
      stop_test();
    end else begin
      chkw("word", rx_word, exp);
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
    end
  endtask

  // ============================================================
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    chk1("ack drive", sda_oe, 1'b0);
    chk1("busy", busy, 1'b0);
    chk1("selected", selected, 1'b0);
    chkw("word", rx_word, 9'h000);
    rst_n = 1'b1;
    host.w(5);
    // one access per row
    foreach (rows[i]) begin
      host.start();
      chk1("busy", busy, 1'b1);
      host.send(rows[i].a, 8, ack);
      chk1("addr ack", ack, rows[i].ka);
      chk1("selected", selected, rows[i].ka);
      host.send(rows[i].d, 8, ack);
      chk1("data ack", ack, rows[i].kd);
      host.stop();
      chk1("busy", busy, 1'b0);
      if (rows[i].kd)
        pop({1'b1, rows[i].d});
      chk1("valid", rx_valid, 1'b0);
    end
    // stalled receiver: two words stored, third refused
    host.start();
    host.send(8'hEA, 8, ack);
    host.send(8'h11, 8, ack);
    host.send(8'h22, 8, ack);
    chk1("second ack", ack, 1'b1);
    host.send(8'h33, 8, ack);
    chk1("full ack", ack, 1'b0);
    host.stop();
    pop({1'b0, 8'h11} | 9'h100);
    pop({1'b0, 8'h22});
    chk1("valid", rx_valid, 1'b0);
    // ignored access, then partial byte, both cut by a new start
    host.start();
    host.send(8'hE8, 8, ack);
    host.start();
    host.send(8'hEA, 8, ack);
    host.send(8'hF0, 4, ack);
    host.start();
    host.send(8'hEA, 8, ack);
    chk1("restart ack", ack, 1'b1);
    host.send(8'h5A, 8, ack);
    host.stop();
    pop({1'b1, 8'h5A});
    // enable low freezes the target: a start goes unseen
    ce = 1'b0;
    host.start();
    chk1("frozen busy", busy, 1'b0);
    ce = 1'b1;
    host.stop();
    chk1("busy", busy, 1'b0);
    // reset in mid-access
    host.start();
    host.send(8'hEA, 8, ack);
    rst_n = 1'b0;
    host.w(2);
    chk1("selected", selected, 1'b0);
    chk1("busy", busy, 1'b0);
    rst_n = 1'b1;
    host.stop();
    chk1("valid", rx_valid, 1'b0);
    stop_test();
  end
endmodule

`default_nettype wire
